// *** sfs_cfg.svh ***
`ifndef SFS_CFG_SVH
`define SFS_CFG_SVH

// ============================================================
// Command opcodes
`define SFS_OP_QUAD_PROG   8'h32
`define SFS_OP_ERASE_4K    8'h20
`define SFS_OP_ERASE_32K   8'h52
`define SFS_OP_ERASE_64K   8'hD8
`define SFS_OP_CHIP_A      8'h60
`define SFS_OP_CHIP_B      8'hC7
`define SFS_OP_SUSPEND     8'h75
`define SFS_OP_RESUME      8'h7A
`define SFS_OP_WREN        8'h06
`define SFS_OP_WRDI        8'h04

// ============================================================
// Frame layout
`define SFS_OPCODE_BITS    6'h08
`define SFS_HEADER_BITS    6'h20
`define SFS_PAGE_BYTES     256
`define SFS_PAGE_FULL      9'h100

// ============================================================
// Timing: times in microseconds, clock rate in MHz
`define SFS_CLK_MHZ              40
`define SFS_PAGE_PROGRAM_TIME_US 1000
`define SFS_ERASE_4K_TIME_US     20000
`define SFS_ERASE_32K_TIME_US    40000
`define SFS_ERASE_64K_TIME_US    80000
`define SFS_ARRAY_ERASE_TIME_US  400000

`endif

// *** sfs_pkg.sv ***
package sfs_pkg;

    // ============================================================
    // Kinds of self-timed operation.
    typedef enum logic [2:0] {
        SFS_OP_NONE    = 3'b000,
        SFS_OP_PROG    = 3'b001,
        SFS_OP_ERA4K   = 3'b010,
        SFS_OP_ERA32K  = 3'b011,
        SFS_OP_ERA64K  = 3'b100,
        SFS_OP_CHIP    = 3'b101
    } sfs_op_t;

    // ============================================================
    // Sequencer states.
    typedef enum logic [1:0] {
        SFS_ST_IDLE = 2'b00,
        SFS_ST_BUSY = 2'b01
    } sfs_state_t;

endpackage

// *** sfs_link_if.sv ***
`timescale 1ns/1ps
`include "sfs_cfg.svh"

interface sfs_link_if;
    logic [7:0]                 opcode;
    logic [23:0]                addr;
    logic                       op_done;
    logic                       addr_done;
    logic                       aligned;
    logic                       frame_tog;
    logic [8:0]                 nbytes;
    logic [`SFS_PAGE_BYTES-1:0] byte_valid;
    logic [7:0]                 rd_idx;
    logic [7:0]                 rd_data;

    modport rx  (output opcode, addr, op_done, addr_done, aligned, frame_tog,
                 nbytes, byte_valid, rd_data, input rd_idx);
    modport seq (input opcode, addr, op_done, addr_done, aligned, frame_tog,
                 nbytes, byte_valid, rd_data, output rd_idx);
endinterface

// *** sfs_link_rx.sv ***
`timescale 1ns/1ps
`include "sfs_cfg.svh"

module sfs_link_rx
    import sfs_pkg::*;
(
    input  wire logic       sck_i,
    input  wire logic       cs_n_i,
    input  wire logic       rstn_i,
    input  wire logic [3:0] io_i,
    sfs_link_if.rx          link
);
    logic [7:0] page_mem [0:`SFS_PAGE_BYTES-1];
    logic       in_frame;
    logic [5:0] bit_cnt;
    logic [2:0] phase;
    logic [6:0] shift;
    logic [3:0] nib;

    // ============================================================
    // Counters restart on the first serial clock edge of each frame.
    wire  [5:0] cur_cnt   = in_frame ? bit_cnt : 6'h00;
    wire  [2:0] cur_ph    = in_frame ? phase : 3'h0;
    wire        quad_data = (link.opcode == `SFS_OP_QUAD_PROG) && (cur_cnt == `SFS_HEADER_BITS);
    wire        byte_in   = quad_data && (cur_ph == 3'h4);
    wire  [7:0] wr_idx    = link.addr[7:0] + link.nbytes[7:0];
    wire  [7:0] in_byte   = {nib, io_i};

    always_ff @(posedge sck_i or posedge cs_n_i)
    begin
        if (cs_n_i)
            in_frame <= 1'b0;
        else
            in_frame <= 1'b1;
    end

    always_ff @(posedge sck_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            bit_cnt         <= 6'h00;
            phase           <= 3'h0;
            shift           <= 7'h00;
            nib             <= 4'h0;
            link.opcode     <= 8'h00;
            link.addr       <= 24'h000000;
            link.nbytes     <= 9'h000;
            link.byte_valid <= '0;
            link.frame_tog  <= 1'b0;
        end
        else
        begin
            link.frame_tog <= in_frame ? link.frame_tog : ~link.frame_tog;
            phase          <= cur_ph + (quad_data ? 3'h4 : 3'h1);
            shift          <= {shift[5:0], io_i[0]};
            nib            <= io_i;
            if (cur_cnt != `SFS_HEADER_BITS)
                bit_cnt <= cur_cnt + 6'h01;
            if (cur_cnt == 6'h07)
            begin
                link.opcode     <= {shift, io_i[0]};
                link.nbytes     <= 9'h000;
                link.byte_valid <= '0;
            end
            if (cur_cnt >= `SFS_OPCODE_BITS && cur_cnt < `SFS_HEADER_BITS)
                link.addr <= {link.addr[22:0], io_i[0]};
            if (byte_in)
            begin
                // The index wraps in the page, so only the last 256 bytes survive.
                link.byte_valid[wr_idx] <= 1'b1;
                // The top bit remembers a full page; the low bits keep wrapping the index.
                link.nbytes <= {link.nbytes[8] | (&link.nbytes[7:0]), link.nbytes[7:0] + 8'h01};
            end
        end
    end

    always_ff @(posedge sck_i)
    begin
        if (byte_in)
            page_mem[wr_idx] <= in_byte;
    end

    assign link.op_done   = bit_cnt >= `SFS_OPCODE_BITS;
    assign link.addr_done = bit_cnt == `SFS_HEADER_BITS;
    assign link.aligned   = phase == 3'h0;
    assign link.rd_data   = page_mem[link.rd_idx];

endmodule // sfs_link_rx

// *** sfs_sequencer.sv ***
`timescale 1ns/1ps
`include "sfs_cfg.svh"

module sfs_sequencer
    import sfs_pkg::*;
#(
    parameter int unsigned PROG_CYCLES   = `SFS_PAGE_PROGRAM_TIME_US * `SFS_CLK_MHZ,
    parameter int unsigned ERA4K_CYCLES  = `SFS_ERASE_4K_TIME_US * `SFS_CLK_MHZ,
    parameter int unsigned ERA32K_CYCLES = `SFS_ERASE_32K_TIME_US * `SFS_CLK_MHZ,
    parameter int unsigned ERA64K_CYCLES = `SFS_ERASE_64K_TIME_US * `SFS_CLK_MHZ,
    parameter int unsigned CHIP_CYCLES   = `SFS_ARRAY_ERASE_TIME_US * `SFS_CLK_MHZ
)
(
    input  wire logic        clock_i,
    input  wire logic        rstn_i,
    input  wire logic        sck_i,
    input  wire logic        cs_n_i,
    input  wire logic [3:0]  io_i,
    input  wire logic        quad_lane_enable_i,
    input  wire logic        prot_en_i,
    input  wire logic [23:0] prot_lo_i,
    input  wire logic [23:0] prot_hi_i,
    input  wire logic [7:0]  buf_idx_i,
    input  wire logic [23:0] rd_addr_i,
    output logic             write_enable_latch_o,
    output logic             write_in_progress_o,
    output logic             erase_suspended_flag_o,
    output logic             program_suspended_flag_o,
    output logic             op_done_o,
    output sfs_op_t          op_kind_o,
    output logic [23:0]      op_addr_o,
    output logic [7:0]       buf_data_o,
    output logic             buf_valid_o,
    output logic             rd_undefined_o
);
    sfs_link_if link ();

    sfs_link_rx u_rx (
        .sck_i  (sck_i),
        .cs_n_i (cs_n_i),
        .rstn_i (rstn_i),
        .io_i   (io_i),
        .link   (link.rx)
    );

    // ============================================================
    // Reset release and crossings from the link domain.
    logic [1:0] rst_q;
    logic       rst_n;
    logic       cs_s1, cs_s2, cs_s3;
    logic       tog_s1, tog_s2, tog_seen;

    assign rst_n = rst_q[1];

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            rst_q <= 2'b00;
        else
            rst_q <= {rst_q[0], 1'b1};
    end

    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {cs_s1, cs_s2, cs_s3}        <= 3'b111;
            {tog_s1, tog_s2, tog_seen}   <= 3'b000;
        end
        else
        begin
            {cs_s1, cs_s2, cs_s3} <= {cs_n_i, cs_s1, cs_s2};
            {tog_s1, tog_s2}      <= {link.frame_tog, tog_s1};
            if (cs_s2 && !cs_s3)
                tog_seen <= tog_s2;
        end
    end

    // ============================================================
    // Functions for block geometry and protection.
    function automatic logic [23:0] blk_base(input logic [23:0] a, input sfs_op_t k);
        case (k)
            SFS_OP_ERA4K:  blk_base = {a[23:12], 12'h000};
            SFS_OP_ERA32K: blk_base = {a[23:15], 15'h0000};
            SFS_OP_ERA64K: blk_base = {a[23:16], 16'h0000};
            default:       blk_base = {a[23:8], 8'h00};
        endcase
    endfunction

    function automatic logic [23:0] blk_last(input logic [23:0] a, input sfs_op_t k);
        case (k)
            SFS_OP_ERA4K:  blk_last = {a[23:12], 12'hFFF};
            SFS_OP_ERA32K: blk_last = {a[23:15], 15'h7FFF};
            SFS_OP_ERA64K: blk_last = {a[23:16], 16'hFFFF};
            default:       blk_last = {a[23:8], 8'hFF};
        endcase
    endfunction

    function automatic logic hits_prot(input logic [23:0] lo, input logic [23:0] hi);
        hits_prot = prot_en_i && (lo <= prot_hi_i) && (hi >= prot_lo_i);
    endfunction

    // ============================================================
    // Sequencer state.
    sfs_state_t  state;
    sfs_op_t     cur_kind, e_kind;
    logic [23:0] cur_addr, p_addr, e_addr;
    logic [31:0] cnt, p_cnt, e_cnt;
    logic        write_enable_latch, psus, esus;

    // ============================================================
    // Command decode at the end of each frame.
    wire        busy     = state == SFS_ST_BUSY;
    wire        cs_rise  = cs_s2 && !cs_s3;
    wire        frame_ok = cs_rise && (tog_s2 != tog_seen) && link.op_done;
    wire        cmd_ok   = frame_ok && link.aligned;
    wire [7:0]  op       = link.opcode;
    wire        is_prog  = op == `SFS_OP_QUAD_PROG;
    wire        is_chip  = (op == `SFS_OP_CHIP_A) || (op == `SFS_OP_CHIP_B);
    wire        is_susp  = op == `SFS_OP_SUSPEND;
    wire        is_res   = op == `SFS_OP_RESUME;
    wire        is_wren  = op == `SFS_OP_WREN;
    wire        is_wrdi  = op == `SFS_OP_WRDI;
    wire        any_sus  = psus || esus;

    wire sfs_op_t blk_kind = (op == `SFS_OP_ERASE_4K)  ? SFS_OP_ERA4K :
                             (op == `SFS_OP_ERASE_32K) ? SFS_OP_ERA32K :
                             (op == `SFS_OP_ERASE_64K) ? SFS_OP_ERA64K : SFS_OP_NONE;
    wire        is_blk   = blk_kind != SFS_OP_NONE;

    wire [23:0] pg_lo    = blk_base(link.addr, SFS_OP_PROG);
    wire [23:0] bk_lo    = blk_base(link.addr, blk_kind);
    wire        prog_bad = !link.aligned || !link.addr_done || (link.nbytes == 9'h000) ||
                           hits_prot(pg_lo, blk_last(link.addr, SFS_OP_PROG)) ||
                           (esus && blk_base(link.addr, e_kind) == e_addr);
    wire        blk_bad  = !link.aligned || !link.addr_done ||
                           hits_prot(bk_lo, blk_last(link.addr, blk_kind)) ||
                           (psus && blk_base(p_addr, blk_kind) == bk_lo);
    wire        chip_bad = !link.aligned || prot_en_i;

    // A second program while one is suspended would clobber the shared page buffer.
    wire prog_try  = frame_ok && !busy && is_prog && quad_lane_enable_i && write_enable_latch && !psus;
    wire blk_try   = frame_ok && !busy && is_blk && write_enable_latch && !esus;
    wire chip_try  = frame_ok && !busy && is_chip && write_enable_latch && !any_sus;
    wire prog_go   = prog_try && !prog_bad;
    wire blk_go    = blk_try && !blk_bad;
    wire chip_go   = chip_try && !chip_bad;
    wire launch    = prog_go || blk_go || chip_go;
    wire wel_kill  = (prog_try && prog_bad) || (blk_try && blk_bad) ||
                     (chip_try && chip_bad);
    wire wren_go   = cmd_ok && !busy && is_wren;
    wire wrdi_go   = cmd_ok && !busy && is_wrdi;
    wire susp_go   = cmd_ok && busy && is_susp && (cur_kind != SFS_OP_CHIP) &&
                     !((cur_kind == SFS_OP_PROG) && esus);
    wire res_go    = cmd_ok && !busy && is_res && any_sus;
    wire finish    = busy && (cnt == 32'h0000_0000) && !susp_go;

    wire sfs_op_t    next_kind = prog_go ? SFS_OP_PROG : blk_go ? blk_kind : SFS_OP_CHIP;
    wire [23:0] next_addr = prog_go ? pg_lo : blk_go ? bk_lo : 24'h000000;
    wire [31:0] next_cnt  = prog_go ? PROG_CYCLES - 32'h1 :
                            (blk_kind == SFS_OP_ERA4K && blk_go)  ? ERA4K_CYCLES - 32'h1 :
                            (blk_kind == SFS_OP_ERA32K && blk_go) ? ERA32K_CYCLES - 32'h1 :
                            blk_go ? ERA64K_CYCLES - 32'h1 : CHIP_CYCLES - 32'h1;

    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state    <= SFS_ST_IDLE;
            cur_kind <= SFS_OP_NONE;
            cur_addr <= 24'h000000;
            cnt      <= 32'h0000_0000;
        end
        else if (launch)
        begin
            state    <= SFS_ST_BUSY;
            cur_kind <= next_kind;
            cur_addr <= next_addr;
            cnt      <= next_cnt;
        end
        else if (res_go)
        begin
            state    <= SFS_ST_BUSY;
            cur_kind <= psus ? SFS_OP_PROG : e_kind;
            cur_addr <= psus ? p_addr : e_addr;
            cnt      <= psus ? p_cnt : e_cnt;
        end
        else if (susp_go || finish)
        begin
            state    <= SFS_ST_IDLE;
            cur_kind <= SFS_OP_NONE;
        end
        else if (busy)
            cnt <= cnt - 32'h1;
    end

    // ============================================================
    // Write enable latch and suspend records.
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
            write_enable_latch <= 1'b0;
        else if (launch || wel_kill || wrdi_go)
            write_enable_latch <= 1'b0;
        else if (wren_go)
            write_enable_latch <= 1'b1;
    end

    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            psus   <= 1'b0;
            esus   <= 1'b0;
            p_addr <= 24'h000000;
            e_addr <= 24'h000000;
            p_cnt  <= 32'h0000_0000;
            e_cnt  <= 32'h0000_0000;
            e_kind <= SFS_OP_NONE;
        end
        else if (susp_go && cur_kind == SFS_OP_PROG)
        begin
            psus   <= 1'b1;
            p_addr <= cur_addr;
            p_cnt  <= cnt;
        end
        else if (susp_go)
        begin
            esus   <= 1'b1;
            e_addr <= cur_addr;
            e_kind <= cur_kind;
            e_cnt  <= cnt;
        end
        else if (res_go && psus)
            psus <= 1'b0;
        else if (res_go)
            esus <= 1'b0;
    end

    // ============================================================
    // Completion report, page buffer readout and suspended-area reads.
    assign link.rd_idx = buf_idx_i;

    wire rd_in_p = psus && (rd_addr_i[23:8] == p_addr[23:8]);
    wire rd_in_e = esus && (blk_base(rd_addr_i, e_kind) == e_addr);

    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            op_done_o      <= 1'b0;
            op_kind_o      <= SFS_OP_NONE;
            op_addr_o      <= 24'h000000;
            buf_data_o     <= 8'h00;
            buf_valid_o    <= 1'b0;
            rd_undefined_o <= 1'b0;
        end
        else
        begin
            op_done_o      <= finish;
            op_kind_o      <= finish ? cur_kind : op_kind_o;
            op_addr_o      <= finish ? cur_addr : op_addr_o;
            buf_data_o     <= link.rd_data;
            buf_valid_o    <= link.byte_valid[buf_idx_i];
            rd_undefined_o <= rd_in_p || rd_in_e;
        end
    end

    assign write_enable_latch_o     = write_enable_latch;
    assign write_in_progress_o      = busy;
    assign erase_suspended_flag_o   = esus;
    assign program_suspended_flag_o = psus;

    // ============================================================
    // Checks.
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n);

    sequence s_started;
        write_in_progress_o && !write_enable_latch_o;
    endsequence

    sequence s_halted_ready;
        !write_in_progress_o ##0 (erase_suspended_flag_o || program_suspended_flag_o);
    endsequence

    a_launch_shows_busy: assert property (launch |=> s_started ##1 write_in_progress_o)
        else $error("Busy flag or latch wrong after launch");
    a_qe_gates_prog: assert property (frame_ok && !busy && is_prog && !quad_lane_enable_i
        |=> !write_in_progress_o)
        else $error("Quad program ran without quad lane enable");
    a_prot_no_run: assert property (frame_ok && !busy && prot_en_i && is_chip
        |=> !write_in_progress_o)
        else $error("Array erase ran while protected");
    a_misalign_blocks: assert property (frame_ok && !busy && !link.aligned
        |=> !write_in_progress_o)
        else $error("Command ran after misaligned chip select");
    a_suspend_halts: assert property (susp_go |=> s_halted_ready)
        else $error("Suspend did not halt with a flag set");
    a_chip_unsuspend: assert property (busy && cur_kind == SFS_OP_CHIP && cs_rise && is_susp &&
        cnt > 32'h1 |=> write_in_progress_o)
        else $error("Array erase was suspended");
    a_idle_susp_ignored: assert property (cs_rise && is_susp && !busy
        |=> $stable(erase_suspended_flag_o) && $stable(program_suspended_flag_o))
        else $error("Idle suspend changed a flag");
    a_resume_prog_first: assert property (res_go && psus && esus
        |=> !program_suspended_flag_o && erase_suspended_flag_o && cur_kind == SFS_OP_PROG)
        else $error("Resume did not restart the program first");
    a_wren_sets_latch: assert property (wren_go |=> write_enable_latch_o)
        else $error("Write enable did not set the latch");
    a_abort_clears_wel: assert property (wel_kill |=> !write_enable_latch_o
        && !write_in_progress_o)
        else $error("Abort left latch set or device busy");
    a_finish_reports: assert property (finish |=> op_done_o && !write_in_progress_o ##1
        !op_done_o)
        else $error("Completion pulse wrong");

endmodule // sfs_sequencer

// *** sfs_host_model.sv ***
`timescale 1ns/1ps
module sfs_host_model (
    output logic       sck_o,
    output logic       cs_n_o,
    output logic [3:0] io_o
);
    // ============================================================
    // Host side of the link; the link clock stands still between frames.
    initial
    begin
        sck_o  = 1'b0;
        cs_n_o = 1'b0;
        io_o   = 4'h5;
        // A chip select rise just after start clears the link's frame flag.
        #1 cs_n_o = 1'b1;
    end
    task automatic pulse(input logic [3:0] v);
        io_o = v;
        #7.5 sck_o = 1'b1;
        #7.5 sck_o = 1'b0;
    endtask
    // Opcode and address go on lane 0 MSB first; quad program data as nibbles high first,
    // trailing bytes of other commands on lane 0 MSB first.
    task automatic frame(input logic [7:0] op, input int ab, input logic [23:0] a,
                         input logic [7:0] d[$]);
        cs_n_o = 1'b0;
        for (int i = 7; i >= 0; i--) pulse({3'h0, op[i]});
        for (int i = 23; i > 23 - ab; i--) pulse({3'h0, a[i]});
        if (op == 8'h32)
            for (int i = 0; i < 2 * d.size(); i++) pulse(i % 2 ? d[i/2][3:0] : d[i/2][7:4]);
        else
            foreach (d[j]) for (int i = 7; i >= 0; i--) pulse({3'h0, d[j][i]});
        #7.5 cs_n_o = 1'b1;
        io_o = ~io_o;
        #300;
    endtask
endmodule // sfs_host_model

// *** test_serial_flash_program_erase_suspend.sv ***
`timescale 1ns/1ps
module test_serial_flash_program_erase_suspend;
    import sfs_pkg::*;
    logic        clock_i = 1'b0;
    logic        rstn_i = 1'b1;
    logic        sck_i, cs_n_i;
    logic [3:0]  io_i;
    logic        quad_lane_enable_i = 1'b0, prot_en_i = 1'b0;
    logic [23:0] prot_lo_i = 24'h010000, prot_hi_i = 24'h01FFFF, rd_addr_i = 24'h000000;
    logic [7:0]  buf_idx_i = 8'h00, buf_data_o;
    logic        write_enable_latch_o, write_in_progress_o, erase_suspended_flag_o;
    logic        program_suspended_flag_o, op_done_o, buf_valid_o, rd_undefined_o;
    sfs_op_t     op_kind_o;
    logic [23:0] op_addr_o, a;
    int          err_count = 0;
    int          checks_done = 0;
    logic [31:0] seed = 32'h4F5D5A5A;
    logic [7:0]  q[$], nil[$], mem[256];
    logic [7:0]  ops[5] = '{8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7};
    sfs_op_t     kinds[5] = '{SFS_OP_ERA4K, SFS_OP_ERA32K, SFS_OP_ERA64K, SFS_OP_CHIP,
                              SFS_OP_CHIP};
    logic [23:0] masks[5] = '{24'hFFF000, 24'hFF8000, 24'hFF0000, 24'h0, 24'h0};
    logic [7:0]  rop[4] = '{8'h20, 8'h60, 8'h60, 8'h20};
    int          rab[4] = '{20, 4, 0, 24};
    always #12.5 clock_i = ~clock_i;
    sfs_host_model sfs_host_model_inst (.sck_o(sck_i), .cs_n_o(cs_n_i), .io_o(io_i));
    sfs_sequencer #(.PROG_CYCLES(60), .ERA4K_CYCLES(60), .ERA32K_CYCLES(60),
        .ERA64K_CYCLES(60), .CHIP_CYCLES(60)) sfs_sequencer_inst (
        .clock_i, .rstn_i, .sck_i, .cs_n_i, .io_i, .quad_lane_enable_i, .prot_en_i,
        .prot_lo_i, .prot_hi_i, .buf_idx_i, .rd_addr_i, .write_enable_latch_o,
        .write_in_progress_o, .erase_suspended_flag_o, .program_suspended_flag_o,
        .op_done_o, .op_kind_o, .op_addr_o, .buf_data_o, .buf_valid_o, .rd_undefined_o);
    // ============================================================
    // Helpers.
    function automatic logic [23:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[23:0];
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: saw %0h, wanted %0h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task automatic send(input logic [7:0] op, input int ab, input logic [23:0] ad,
                        input logic [7:0] d[$]);
        sfs_host_model_inst.frame(op, ab, ad, d);
        cyc(1);
    endtask
    task automatic stat(input logic write_in_progress, input logic write_enable_latch);
        check(write_in_progress_o, write_in_progress);
        check(write_enable_latch_o, write_enable_latch);
    endtask
    // The op_done_o pulse is polled for completion, up to 200 cycles, rather than waiting a fixed time.
    task automatic wait_done();
        int k;
        for (k = 0; k < 200 && op_done_o !== 1'b1; k++) cyc(1);
        check(k < 200, 1);
    endtask
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        #200000;
        err_count++;
        finish_test();
    end
    // ============================================================
    // Scenarios.
    initial
    begin
        #1 rstn_i = 1'b0;
        cyc(8);
        rstn_i = 1'b1;
        cyc(8);
        repeat (258) q.push_back(rnd());
        send(8'h06, 0, 0, nil);
        send(8'h32, 24, 24'h0001FE, q);
        stat(1'b0, 1'b1);
        quad_lane_enable_i = 1'b1;
        send(8'h32, 24, 24'h0001FE, q);
        stat(1'b1, 1'b0);
        wait_done();
        check(op_kind_o, SFS_OP_PROG);
        check(op_addr_o, 24'h000100);
        foreach (q[n]) mem[(8'hFE + n) % 256] = q[n];
        for (int i = 0; i < 256; i++)
        begin
            buf_idx_i = i[7:0];
            cyc(1);
            check(buf_data_o, mem[i]);
            check(buf_valid_o, 1'b1);
        end
        $display("quad program test done");
        for (int i = 0; i < 5; i++)
        begin
            a = rnd() & 24'h07FFFF;
            send(8'h06, 0, 0, nil);
            send(ops[i], i < 3 ? 24 : 0, a, q[0:0]);
            stat(1'b1, 1'b0);
            wait_done();
            check(op_kind_o, kinds[i]);
            check(op_addr_o, a & masks[i]);
        end
        $display("erase test done");
        for (int i = 0; i < 4; i++)
        begin
            prot_en_i = i > 1;
            send(8'h06, 0, 0, nil);
            send(rop[i], rab[i], 24'h012345, nil);
            stat(1'b0, 1'b0);
        end
        send(8'h06, 0, 0, nil);
        send(8'h32, 24, 24'h0133FF, q[0:1]);
        check(write_in_progress_o, 1'b0);
        prot_en_i = 1'b0;
        $display("refusal test done");
        send(8'h06, 0, 0, nil);
        send(8'h52, 24, 24'h02ABCD, nil);
        send(8'h75, 0, 0, nil);
        stat(1'b0, 1'b0);
        check(erase_suspended_flag_o, 1'b1);
        rd_addr_i = 24'h028000;
        cyc(2);
        check(rd_undefined_o, 1'b1);
        rd_addr_i = 24'h030000;
        cyc(2);
        check(rd_undefined_o, 1'b0);
        send(8'h06, 0, 0, nil);
        send(8'h32, 24, 24'h02F000, q[0:3]);
        stat(1'b0, 1'b0);
        send(8'h7A, 0, 0, nil);
        stat(1'b1, 1'b0);
        check(erase_suspended_flag_o, 1'b0);
        wait_done();
        check(op_addr_o, 24'h028000);
        send(8'h75, 0, 0, nil);
        check(erase_suspended_flag_o | program_suspended_flag_o, 1'b0);
        send(8'h06, 0, 0, nil);
        send(8'hC7, 0, 0, nil);
        send(8'h75, 0, 0, nil);
        stat(1'b1, 1'b0);
        wait_done();
        send(8'h06, 0, 0, nil);
        send(8'h32, 24, 24'h000180, q[0:3]);
        buf_idx_i = 8'h84;
        cyc(1);
        check(buf_valid_o, 1'b0);
        send(8'h75, 0, 0, nil);
        stat(1'b0, 1'b0);
        check(program_suspended_flag_o, 1'b1);
        rd_addr_i = 24'h0001C0;
        cyc(2);
        check(rd_undefined_o, 1'b1);
        send(8'h06, 0, 0, nil);
        send(8'hD8, 24, 24'h05ABCD, nil);
        stat(1'b1, 1'b0);
        send(8'h75, 0, 0, nil);
        check(erase_suspended_flag_o & program_suspended_flag_o, 1'b1);
        send(8'h7A, 0, 0, nil);
        stat(1'b1, 1'b0);
        check(erase_suspended_flag_o & !program_suspended_flag_o, 1'b1);
        send(8'h75, 0, 0, nil);
        stat(1'b1, 1'b0);
        wait_done();
        check(op_kind_o, SFS_OP_PROG);
        send(8'h7A, 0, 0, nil);
        wait_done();
        check(op_addr_o, 24'h050000);
        $display("suspend test done");
        finish_test();
    end
endmodule // test_serial_flash_program_erase_suspend
